//--- rtl/fcl_loader.sv
// Flash to FPGA configuration loader, serial and parallel delivery
`timescale 1ns/1ns
module fcl_loader
  import fcl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Static options (straps)
  input wire logic [1:0] i_mode,
  input wire logic i_wide_flash,
  input wire logic i_remote_mode,
  // Page selection
  input wire logic [FCL_PAGE_W-1:0] i_page_select_pins,
  input wire logic [FCL_PAGE_W-1:0] i_remote_page_pins,
  // Flash side
  output logic [FCL_ADDR_W-1:0] o_flash_addr,
  output logic o_flash_oe_n,
  input wire logic [15:0] i_flash_data,
  // FPGA side
  output logic o_cfg_start_n,
  output logic o_cfg_clock_out,
  output logic o_serial_cfg_out,
  output logic [7:0] o_cfg_data,
  output logic o_cfg_write_strobe_n,
  output logic o_cfg_read_strobe_n,
  output logic o_cfg_select_lo_n,
  output logic o_cfg_select_hi,
  input wire logic i_cfg_error_status_n,
  input wire logic i_cfg_complete_flag,
  // Status
  output logic o_busy
);
  // Two-stage synchronisers for FPGA status pins and page pins
  logic [1:0] st_s1, st_s2;
  logic [FCL_PAGE_W-1:0] pg_s1, pg_s2, rp_s1, rp_s2;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // Status idles high, done idles low: no false fall after reset
      st_s1 <= 2'h2;
      st_s2 <= 2'h2;
      pg_s1 <= '0;
      pg_s2 <= '0;
      rp_s1 <= '0;
      rp_s2 <= '0;
    end else begin
      st_s1 <= {i_cfg_error_status_n, i_cfg_complete_flag};
      st_s2 <= st_s1;
      pg_s1 <= i_page_select_pins;
      pg_s2 <= pg_s1;
      rp_s1 <= i_remote_page_pins;
      rp_s2 <= rp_s1;
    end
  end
  wire logic stat_ok = st_s2[1];
  wire logic done_s = st_s2[0];

  fcl_state_t state, next_state;
  logic [FCL_ADDR_W-1:0] addr, next_addr;
  logic [15:0] shreg, next_shreg;
  logic [4:0] units, next_units;   // Units left in current word
  logic [3:0] cnt, next_cnt;       // Wait counter / strobe phase counter
  logic [1:0] hold, next_hold;     // Extra clock pulses left for the current byte
  logic done_d, next_done_d;
  logic clk_o, next_clk_o;
  logic sdo, next_sdo;
  logic [7:0] pdo, next_pdo;
  logic ws_n, next_ws_n;
  logic cs_act, next_cs_act;
  logic cfg_n, next_cfg_n;

  logic is_serial_mode, is_async_mode;
  logic [4:0] units_per_word;
  logic [FCL_PAGE_W-1:0] page;
  always_comb begin
    is_serial_mode = (i_mode == FCL_SERIAL_MODE);
    is_async_mode = (i_mode == FCL_ASYNC_PARALLEL_MODE);
    // Bits or bytes per fetched word
    if (is_serial_mode) begin
      units_per_word = i_wide_flash ? 5'h10 : 5'h08;
    end else begin
      units_per_word = i_wide_flash ? 5'h02 : 5'h01;
    end
    // Page source depends on upgrade mode
    page = i_remote_mode ? rp_s2 : pg_s2;
  end

  // Sequencer: fetch, then pace units out in the selected mode
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_shreg = shreg;
    next_units = units;
    next_cnt = cnt;
    next_hold = hold;
    next_done_d = done_s;
    next_clk_o = clk_o;
    next_sdo = sdo;
    next_pdo = pdo;
    next_ws_n = ws_n;
    next_cs_act = cs_act;
    next_cfg_n = cfg_n;
    unique case (state)
      FCL_ST_START: begin
        // Pulse configuration request low, then load page base
        next_cfg_n = 1'b0;
        next_clk_o = 1'b0;
        next_ws_n = 1'b1;
        next_cs_act = 1'b0;
        if (cnt == 4'(FCL_CFG_LOW_CYC - 1)) begin
          next_cnt = '0;
          next_cfg_n = 1'b1;
          next_addr = FCL_ADDR_W'(page) << FCL_PAGE_SHIFT;
          next_state = FCL_ST_FETCH;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      FCL_ST_FETCH: begin
        // Wait flash access, then latch the low lane, or both lanes on wide flash
        next_clk_o = 1'b0;
        if (cnt == 4'(FCL_FLASH_CYC - 1)) begin
          next_cnt = '0;
          next_shreg = i_wide_flash ? i_flash_data
                                    : {8'h00, i_flash_data[7:0]};
          next_addr = addr + 1'b1;
          next_units = units_per_word;
          next_state = FCL_ST_NEXT;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      FCL_ST_NEXT: begin
        // Present next unit while clock is low
        if (units == 5'h00) begin
          next_state = FCL_ST_FETCH;
        end else begin
          next_units = units - 5'h01;
          if (is_serial_mode) begin
            next_sdo = shreg[0];
            next_shreg = {1'b0, shreg[15:1]};
          end else begin
            next_pdo = shreg[7:0];
            next_shreg = {8'h00, shreg[15:8]};
          end
          // Decompression holds each byte four pulses
          next_hold = (i_mode == FCL_FAST_PARALLEL_DEC_MODE) ? 2'h3 : 2'h0;
          next_state = is_async_mode ? FCL_ST_STRB : FCL_ST_LOW;
        end
      end
      FCL_ST_LOW: begin
        // Data set up one cycle before the rising edge
        next_clk_o = 1'b1;
        next_state = FCL_ST_HIGH;
      end
      FCL_ST_HIGH: begin
        next_clk_o = 1'b0;
        if (hold != 2'h0) begin
          next_hold = hold - 2'h1;
          next_state = FCL_ST_LOW;
        end else if (done_s) begin
          next_state = FCL_ST_USER;
        end else begin
          next_state = FCL_ST_NEXT;
        end
      end
      FCL_ST_STRB: begin
        // Select, write strobe low for a phase, then release
        next_cs_act = 1'b1;
        next_cnt = cnt + 4'h1;
        if (cnt == 4'h0) begin
          next_ws_n = 1'b0;
        end else if (cnt == 4'(FCL_STRB_CYC)) begin
          next_ws_n = 1'b1;
        end else if (cnt == 4'(2 * FCL_STRB_CYC)) begin
          next_cnt = '0;
          next_cs_act = 1'b0;
          next_state = done_s ? FCL_ST_USER : FCL_ST_NEXT;
        end
      end
      FCL_ST_USER: begin
        // Configured; idle until the done flag falls
        next_cnt = '0;
      end
      default: begin
        next_state = FCL_ST_START;
      end
    endcase
    // Error status during configuration restarts
    // Request drops at once and a pending pulse is cut, so the FPGA
    // never sees a stray clock edge during the restart
    if (!stat_ok && state != FCL_ST_START && state != FCL_ST_USER) begin
      next_state = FCL_ST_START;
      next_cnt = '0;
      next_cfg_n = 1'b0;
      next_clk_o = 1'b0;
    end
    // Done flag falling (reconfig request) restarts
    if (done_d && !done_s) begin
      next_state = FCL_ST_START;
      next_cnt = '0;
      next_cfg_n = 1'b0;
      next_clk_o = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= FCL_ST_START;
      addr <= '0;
      shreg <= '0;
      units <= '0;
      cnt <= '0;
      hold <= '0;
      done_d <= 1'b0;
      clk_o <= 1'b0;
      sdo <= 1'b0;
      pdo <= '0;
      ws_n <= 1'b1;
      cs_act <= 1'b0;
      cfg_n <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      shreg <= next_shreg;
      units <= next_units;
      cnt <= next_cnt;
      hold <= next_hold;
      done_d <= next_done_d;
      clk_o <= next_clk_o;
      sdo <= next_sdo;
      pdo <= next_pdo;
      ws_n <= next_ws_n;
      cs_act <= next_cs_act;
      cfg_n <= next_cfg_n;
    end
  end

  // Outputs from flops; flash enable and busy decoded from state
  assign o_flash_addr = addr;
  assign o_flash_oe_n = (state != FCL_ST_FETCH);
  assign o_cfg_start_n = cfg_n;
  assign o_cfg_clock_out = clk_o;
  assign o_serial_cfg_out = sdo;
  assign o_cfg_data = pdo;
  assign o_cfg_write_strobe_n = ws_n;
  // Read strobe is never used for status polling; held inactive
  assign o_cfg_read_strobe_n = 1'b1;
  assign o_cfg_select_lo_n = ~cs_act;
  assign o_cfg_select_hi = cs_act;
  assign o_busy = (state != FCL_ST_USER);

  // Assertions
  a_data_stable_edge: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $rose(o_cfg_clock_out)
      |-> $stable(o_cfg_data) && $stable(o_serial_cfg_out))
    else $error("data changed at configuration clock rise");
  a_async_no_clock: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    is_async_mode |-> !o_cfg_clock_out)
    else $error("clock pulsed in async parallel mode");
  a_strobe_selected: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    !o_cfg_write_strobe_n |-> !o_cfg_select_lo_n && o_cfg_select_hi)
    else $error("write strobe without chip selects");
  a_error_restart: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (!stat_ok && state != FCL_ST_START && state != FCL_ST_USER
      && done_d == done_s) |=> state == FCL_ST_START)
    else $error("error status did not restart");
  a_done_fall: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (done_d && !done_s) |=> state == FCL_ST_START ##1 !o_cfg_start_n)
    else $error("done fall did not restart");
  a_page_base: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (state == FCL_ST_START && next_state == FCL_ST_FETCH)
      |=> o_flash_addr == (FCL_ADDR_W'(page) << FCL_PAGE_SHIFT))
    else $error("page base address wrong");
  a_fpp_one_pulse: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_mode == FCL_FAST_PARALLEL_MODE && state == FCL_ST_NEXT
      && units != 5'h00)
      |=> state == FCL_ST_LOW ##1 o_cfg_clock_out ##1 !o_cfg_clock_out)
    else $error("fast parallel pulse wrong");
  a_word_units: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (state == FCL_ST_FETCH && next_state == FCL_ST_NEXT)
      |=> units == units_per_word)
    else $error("unit count per word wrong");
  a_fetch_addr_stable: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (!o_flash_oe_n ##1 !o_flash_oe_n) |-> $stable(o_flash_addr))
    else $error("flash address moved during a fetch");
  a_start_low_len: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $fell(o_cfg_start_n) |-> !o_cfg_start_n [*8] ##1 o_cfg_start_n)
    else $error("configuration request not low for eight cycles");
  a_serial_bus_idle: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    is_serial_mode |-> $stable(o_cfg_data))
    else $error("parallel bus moved in serial mode");
endmodule

//--- rtl/fcl_pkg.sv
// Constants and types shared by the flash configuration loader
// Operation
// - The page comes from the select pins, or remote pins in remote mode.
// - Flash is 8 or 16 bits wide; 16-bit flash adds the upper byte lane.
// - Serial mode shifts each fetched byte or halfword out on one pin.
// - The three parallel modes drive data out on an eight-bit bus.
// - Serial mode makes the configuration clock, one bit per pulse.
// - Serial mode fetches the next flash word after 8 or 16 clocks.
// - Fast parallel mode makes the clock and gives one new byte per pulse.
// - Fast parallel mode fetches the next word after one or two clocks.
// - With decompression each byte is held for four clock pulses.
// - Decompression fetches the next word every four or eight clocks.
// - Async parallel paces each byte by the write strobe and selects; read strobe stays high.
// - Async parallel reads the next word after its one or two bytes go out.
// - A low error status during configuration restarts configuration.
// - The FPGA drops its done flag to reload; the loader then restarts.
package fcl_pkg;
  localparam int FCL_ADDR_W = 24;
  localparam int FCL_PAGE_W = 3;
  // Page base is page number shifted to this bit of the word address
  localparam int FCL_PAGE_SHIFT = 20;
  // Flash access time, ns, and derived cycles at 10 ns (round up)
  localparam int FCL_FLASH_ACC_NS = 100;
  localparam int FCL_CLK_NS = 10;
  localparam int FCL_FLASH_CYC =
    (FCL_FLASH_ACC_NS + FCL_CLK_NS - 1) / FCL_CLK_NS;
  // Cycles each strobe phase lasts in async parallel mode
  localparam int FCL_STRB_CYC = 4;
  // Reset and restart: hold time of the configuration request low
  localparam int FCL_CFG_LOW_CYC = 8;
  localparam logic [1:0] FCL_SERIAL_MODE = 2'h0;
  localparam logic [1:0] FCL_FAST_PARALLEL_MODE = 2'h1;
  localparam logic [1:0] FCL_FAST_PARALLEL_DEC_MODE = 2'h2;
  localparam logic [1:0] FCL_ASYNC_PARALLEL_MODE = 2'h3;
  typedef enum logic [2:0] {
    FCL_ST_START, FCL_ST_FETCH, FCL_ST_LOW, FCL_ST_HIGH,
    FCL_ST_STRB, FCL_ST_NEXT, FCL_ST_USER
  } fcl_state_t;
endpackage

//--- testbench/fcl_flash_model.sv
// Flash memory model that drives an address-keyed pattern while read
`timescale 1ns/1ns
module fcl_flash_model
  import fcl_pkg::*;
(
  // Flash control
  input wire logic [FCL_ADDR_W-1:0] i_addr,
  input wire logic i_oe_n,
  // Flash data
  output logic [15:0] o_data
);
  logic [7:0] lo;
  initial o_data = 16'h0;
  // Low byte carries page and word offset, high byte its inverse
  assign lo = {i_addr[22:20], i_addr[4:0]};
  // A released bus shows the inverse of the last value, so stale data fails
  always @(i_oe_n or lo) begin
    o_data = i_oe_n ? ~o_data : {~lo, lo};
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the flash configuration loader
`timescale 1ns/1ns
module tb;
  import fcl_pkg::*;
  typedef struct packed {
    logic [1:0] m;
    logic w;
    logic r;
    logic [2:0] ps;
    logic [2:0] rp;
    logic [2:0] pg;
  } fcl_tb_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] mode = 2'h0;
  logic wide = 1'b0;
  logic remote = 1'b0;
  logic err_n = 1'b1;
  logic done = 1'b0;
  logic [2:0] psel = 3'h0;
  logic [2:0] rpins = 3'h0;
  logic [23:0] faddr;
  logic [15:0] fdata;
  logic [7:0] pdata;
  logic foe_n, st_n, ck, sd, ws_n, rs_n, cs_n, cs, busy;
  int bad_count = 0;
  int samples_checked = 0;
  // Mode, width, remote, select pins, remote pins, expected page
  fcl_tb_row_t rows [8] = '{
    {2'h0, 1'h0, 1'h0, 3'h3, 3'h5, 3'h3}, {2'h0, 1'h1, 1'h1, 3'h3, 3'h5, 3'h5},
    {2'h1, 1'h0, 1'h0, 3'h7, 3'h0, 3'h7}, {2'h1, 1'h1, 1'h0, 3'h1, 3'h6, 3'h1},
    {2'h2, 1'h0, 1'h1, 3'h2, 3'h4, 3'h4}, {2'h2, 1'h1, 1'h0, 3'h6, 3'h1, 3'h6},
    {2'h3, 1'h0, 1'h0, 3'h5, 3'h2, 3'h5}, {2'h3, 1'h1, 1'h1, 3'h0, 3'h7, 3'h7}};

  always #5 clk = ~clk;

  fcl_flash_model flash (.i_addr(faddr), .i_oe_n(foe_n), .o_data(fdata));
  fcl_loader DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_mode(mode),
    .i_wide_flash(wide), .i_remote_mode(remote), .i_page_select_pins(psel),
    .i_remote_page_pins(rpins), .o_flash_addr(faddr), .o_flash_oe_n(foe_n),
    .i_flash_data(fdata), .o_cfg_start_n(st_n), .o_cfg_clock_out(ck),
    .o_serial_cfg_out(sd), .o_cfg_data(pdata), .o_cfg_write_strobe_n(ws_n),
    .o_cfg_read_strobe_n(rs_n), .o_cfg_select_lo_n(cs_n),
    .o_cfg_select_hi(cs), .i_cfg_error_status_n(err_n),
    .i_cfg_complete_flag(done), .o_busy(busy));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  // Bounded wait at falling edges; running out counts as a mismatch
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (s !== v) check(8'h0, 8'h1);
  endtask

  // Byte k of a page: low lane first on wide flash
  function automatic logic [7:0] exp_byte(input logic [2:0] pg, input int k);
    int w;
    logic [7:0] lo;
    w = wide ? k / 2 : k;
    lo = {pg, w[4:0]};
    return (wide && k % 2 == 1) ? ~lo : lo;
  endfunction

  // Collect one delivered byte the way the FPGA would see it
  task automatic get_byte(output logic [7:0] b);
    int i;
    int reps;
    b = 8'h0;
    reps = (mode == FCL_SERIAL_MODE) ? 8 :
           (mode == FCL_FAST_PARALLEL_DEC_MODE) ? 4 : 1;
    if (mode == FCL_ASYNC_PARALLEL_MODE) begin
      wait_lvl(ws_n, 1'b0);
      b = pdata;
      check({5'h0, cs_n, cs, rs_n}, 8'h3);
      wait_lvl(ws_n, 1'b1);
    end else begin
      for (i = 0; i < reps; i++) begin
        wait_lvl(ck, 1'b1);
        if (mode == FCL_SERIAL_MODE) b[i] = sd;
        else if (i == 0) b = pdata;
        else check(pdata, b);
        wait_lvl(ck, 1'b0);
      end
    end
  endtask

  task automatic stream(input logic [2:0] pg, input int n);
    logic [7:0] b;
    for (int k = 0; k < n; k++) begin
      get_byte(b);
      check(b, exp_byte(pg, k));
    end
  endtask

  // Reset for 20 cycles; start request and busy must already be asserted
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    done = 1'b0;
    repeat (20) @(negedge clk);
    check({6'h0, st_n, busy}, 8'h1);
    rst_b = 1'b1;
  endtask

  // Done flag: high ends the run, falling restarts it
  task automatic finish_cfg();
    done = 1'b1;
    wait_lvl(busy, 1'b0);
    check({7'h0, busy}, 8'h0);
    done = 1'b0;
    wait_lvl(st_n, 1'b0);
    check({7'h0, st_n}, 8'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs under two thousand cycles; give it ample margin
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    foreach (rows[r]) begin
      @(negedge clk);
      rst_b = 1'b0; // Straps only move while the loader is held
      {mode, wide, remote, psel, rpins} = rows[r][12:3];
      do_reset();
      stream(rows[r].pg, 4);
      finish_cfg();
    end
    // Error during configuration restarts from the page base
    rst_b = 1'b0;
    mode = FCL_SERIAL_MODE;
    wide = 1'b1;
    do_reset();
    stream(3'h7, 3);
    err_n = 1'b0;
    wait_lvl(st_n, 1'b0);
    check({7'h0, st_n}, 8'h0);
    err_n = 1'b1;
    stream(3'h7, 2);
    // FPGA moves the remote pins, then drops done to reload
    rst_b = 1'b0;
    mode = FCL_FAST_PARALLEL_MODE;
    wide = 1'b0;
    rpins = 3'h5;
    do_reset();
    stream(3'h5, 2);
    done = 1'b1;
    wait_lvl(busy, 1'b0);
    rpins = 3'h2;
    repeat (4) @(negedge clk);
    done = 1'b0;
    wait_lvl(st_n, 1'b0);
    stream(3'h2, 2);
    final_report();
  end
endmodule
